// ---- design/srwt_pkg.sv ----
// package: constants and carriers for the supervisor reset/watchdog timing
package srwt_pkg;
    // ------------------------------------------------------------
    // clock
    // ------------------------------------------------------------
    localparam int CLK_NS = 100;
    // ------------------------------------------------------------
    // times in their own units
    // ------------------------------------------------------------
    localparam int POR_50_MS      = 50;
    localparam int POR_200_MS     = 200;
    localparam int POR_400_MS     = 400;
    localparam int POR_800_MS     = 800;
    localparam int WDT_1400_MS    = 1400;
    localparam int WDT_200_MS     = 200;
    localparam int WDT_25_MS      = 25;
    localparam int TO_LONG_MS     = 200;
    localparam int TO_SHORT_US    = 25000;
    localparam int NVW_TYP_MS     = 5;
    localparam int NVW_MAX_MS     = 10;
    localparam int RSP_MIN_NS     = 1000;
    localparam int MD_MIN_NS      = 500;
    localparam int LR_TYP_NS      = 500;
    localparam int GLITCH_NS      = 50;
    // ------------------------------------------------------------
    // derived cycle counts
    // ------------------------------------------------------------
    localparam int CYC_PER_MS     = 1000000 / CLK_NS;
    localparam int POR_50_CYC     = POR_50_MS * CYC_PER_MS;
    localparam int POR_200_CYC    = POR_200_MS * CYC_PER_MS;
    localparam int POR_400_CYC    = POR_400_MS * CYC_PER_MS;
    localparam int POR_800_CYC    = POR_800_MS * CYC_PER_MS;
    localparam int WDT_1400_CYC   = WDT_1400_MS * CYC_PER_MS;
    localparam int WDT_200_CYC    = WDT_200_MS * CYC_PER_MS;
    localparam int WDT_25_CYC     = WDT_25_MS * CYC_PER_MS;
    localparam int TO_LONG_CYC    = TO_LONG_MS * CYC_PER_MS;
    localparam int TO_SHORT_CYC   = TO_SHORT_US * 1000 / CLK_NS;
    localparam int NVW_CYC        = NVW_TYP_MS * CYC_PER_MS;
    localparam int RSP_CYC        = (RSP_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int MD_CYC         = (MD_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int LR_CYC_RAW     = LR_TYP_NS / CLK_NS;
    localparam int LR_CYC         = LR_CYC_RAW < 1 ? 1 : LR_CYC_RAW;
    localparam int GLITCH_CYC_RAW = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int GLITCH_CYC     = GLITCH_CYC_RAW < 1 ? 1 : GLITCH_CYC_RAW;
    // ------------------------------------------------------------
    // settings
    // ------------------------------------------------------------
    localparam logic [1:0] POR_SEL_RST = 2'h1;
    localparam logic [1:0] WDT_SEL_RST = 2'h3;
    localparam logic [1:0] WDT_SEL_OFF = 2'h3;
    localparam logic [1:0] WDT_SEL_25  = 2'h2;
    localparam int CNT_W = 24;

    typedef struct packed {
        logic [1:0] por_sel;
        logic [1:0] wdt_sel;
    } srwt_cfg_s;

    typedef enum logic [2:0] {
        SR_POR, SR_RUN, SR_WDT_RST, SR_MAN_RST, SR_LOW_RST
    } srwt_state_e;
endpackage

// ---- design/srwt_top.sv ----
// supervisor reset and watchdog timing core
module srwt_top
    import srwt_pkg::*;
#(
    parameter int POR_50   = POR_50_CYC,
    parameter int POR_200  = POR_200_CYC,
    parameter int POR_400  = POR_400_CYC,
    parameter int POR_800  = POR_800_CYC,
    parameter int WDT_1400 = WDT_1400_CYC,
    parameter int WDT_200  = WDT_200_CYC,
    parameter int WDT_25   = WDT_25_CYC,
    parameter int TO_LONG  = TO_LONG_CYC,
    parameter int TO_SHORT = TO_SHORT_CYC,
    parameter int NVW      = NVW_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire srwt_pkg::srwt_cfg_s cfg,
    input  wire logic              supply_low,
    input  wire logic              manual_reset_in,
    input  wire logic              wdt_restart,
    input  wire logic              write_stop,
    output logic                   reset_out,
    output logic                   low_supply_warn,
    output logic                   nv_busy
);
    import srwt_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [CNT_W-1:0] por_len(input logic [1:0] s);
        case (s)
            2'h0:    por_len = CNT_W'(POR_50);
            2'h1:    por_len = CNT_W'(POR_200);
            2'h2:    por_len = CNT_W'(POR_400);
            default: por_len = CNT_W'(POR_800);
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] wdt_len(input logic [1:0] s);
        case (s)
            2'h0:    wdt_len = CNT_W'(WDT_1400);
            2'h1:    wdt_len = CNT_W'(WDT_200);
            default: wdt_len = CNT_W'(WDT_25);
        endcase
    endfunction

    // ------------------------------------------------------------
    // glitch filters: level must hold GLITCH_CYC+2 samples
    // ------------------------------------------------------------
    logic [3:0] raw, filt, next_filt;
    logic [3:0] prev, next_prev;
    logic [3:0] hold [4];
    logic [3:0] next_hold [4];
    assign raw = {write_stop, wdt_restart, manual_reset_in, supply_low};

    always_comb begin
        next_prev = raw;
        next_filt = filt;
        for (int i = 0; i < 4; i++) begin
            next_hold[i] = hold[i];
            if (raw[i] != prev[i]) begin
                next_hold[i] = 4'h0;
            end else if (hold[i] < 4'(GLITCH_CYC)) begin
                next_hold[i] = hold[i] + 4'h1;
            end else begin
                next_filt[i] = raw[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev <= 4'h0;
            filt <= 4'h0;
            for (int i = 0; i < 4; i++) hold[i] <= 4'h0;
        end else begin
            prev <= next_prev;
            filt <= next_filt;
            for (int i = 0; i < 4; i++) hold[i] <= next_hold[i];
        end
    end

    // ------------------------------------------------------------
    // restart pulse width and stop edge
    // ------------------------------------------------------------
    logic [3:0] rsp_cnt, next_rsp_cnt;
    logic       rsp_done, next_rsp_done;
    logic       stop_d, next_stop_d;
    logic       restart_evt, stop_evt;
    // short restart pulses are dropped on purpose: the host owes 1 us
    assign restart_evt = filt[2] && !rsp_done &&
                         rsp_cnt >= 4'(RSP_CYC - 1);
    assign stop_evt = filt[3] && !stop_d;

    always_comb begin
        next_stop_d   = filt[3];
        next_rsp_cnt  = filt[2] ? (rsp_cnt == 4'hf ? rsp_cnt
                                   : rsp_cnt + 4'h1) : 4'h0;
        next_rsp_done = filt[2] && (rsp_done || restart_evt);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rsp_cnt  <= 4'h0;
            rsp_done <= 1'b0;
            stop_d   <= 1'b0;
        end else begin
            rsp_cnt  <= next_rsp_cnt;
            rsp_done <= next_rsp_done;
            stop_d   <= next_stop_d;
        end
    end

    // ------------------------------------------------------------
    // reset sequencer
    // ------------------------------------------------------------
    srwt_state_e state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt, wdt, next_wdt;
    logic [3:0]       md, next_md, lr, next_lr;
    logic             next_reset, next_warn;
    logic             wdt_on;
    assign wdt_on = cfg.wdt_sel != WDT_SEL_OFF;

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_wdt   = wdt;
        next_md    = filt[1] ? (md == 4'hf ? md : md + 4'h1) : 4'h0;
        next_lr    = filt[0] ? (lr == 4'hf ? lr : lr + 4'h1) : 4'h0;
        next_warn  = filt[0];
        next_reset = reset_out;
        case (state)
            SR_POR: begin
                next_reset = 1'b1;
                if (filt[0]) begin
                    next_cnt = '0;
                end else if (cnt + 1'b1 >= por_len(cfg.por_sel)) begin
                    next_state = SR_RUN;
                    next_reset = 1'b0;
                    next_wdt   = '0;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            SR_RUN: begin
                next_reset = 1'b0;
                if (filt[0] && lr >= 4'(LR_CYC)) begin
                    next_state = SR_LOW_RST;
                    next_reset = 1'b1;
                end else if (filt[1] && md >= 4'(MD_CYC - 1)) begin
                    next_state = SR_MAN_RST;
                    next_reset = 1'b1;
                end else if (!wdt_on || restart_evt) begin
                    next_wdt = '0;
                end else if (wdt + 1'b1 >= wdt_len(cfg.wdt_sel)) begin
                    next_state = SR_WDT_RST;
                    next_reset = 1'b1;
                    next_cnt   = '0;
                end else begin
                    next_wdt = wdt + 1'b1;
                end
            end
            SR_WDT_RST: begin
                next_reset = 1'b1;
                if (cnt + 1'b1 >= (cfg.wdt_sel == WDT_SEL_25 ?
                        CNT_W'(TO_SHORT) : CNT_W'(TO_LONG))) begin
                    next_state = SR_RUN;
                    next_reset = 1'b0;
                    next_wdt   = '0;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            SR_MAN_RST: begin
                next_reset = 1'b1;
                // release reuses the power-on delay once the button lets go
                if (!filt[1]) begin
                    next_state = SR_POR;
                    next_cnt   = '0;
                end
            end
            SR_LOW_RST: begin
                next_reset = 1'b1;
                if (!filt[0]) begin
                    next_state = SR_POR;
                    next_cnt   = '0;
                end
            end
            default: begin
                next_state = SR_POR;
                next_cnt   = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state           <= SR_POR;
            cnt             <= '0;
            wdt             <= '0;
            md              <= 4'h0;
            lr              <= 4'h0;
            reset_out       <= 1'b1;
            low_supply_warn <= 1'b0;
        end else begin
            state           <= next_state;
            cnt             <= next_cnt;
            wdt             <= next_wdt;
            md              <= next_md;
            lr              <= next_lr;
            reset_out       <= next_reset;
            low_supply_warn <= next_warn;
        end
    end

    // ------------------------------------------------------------
    // self-timed nonvolatile write
    // ------------------------------------------------------------
    logic [CNT_W-1:0] nvc, next_nvc;
    logic             next_busy;

    always_comb begin
        next_nvc  = nvc;
        next_busy = nv_busy;
        if (nv_busy) begin
            if (nvc + 1'b1 >= CNT_W'(NVW)) begin
                next_busy = 1'b0;
            end else begin
                next_nvc = nvc + 1'b1;
            end
        end else if (stop_evt) begin
            next_busy = 1'b1;
            next_nvc  = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nvc     <= '0;
            nv_busy <= 1'b0;
        end else begin
            nvc     <= next_nvc;
            nv_busy <= next_busy;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_POR_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        state == SR_POR |-> reset_out)
        else $error("reset low during power-on delay");
    AST_WDT_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        state == SR_RUN && !wdt_on |=> state != SR_WDT_RST)
        else $error("watchdog fired while off");
    AST_WDT_TO: assert property (@(posedge clk) disable iff (!rst_n)
        state == SR_WDT_RST |-> reset_out)
        else $error("reset dropped in watchdog time-out");
    AST_WDT_SHORT: assert property (@(posedge clk) disable iff (!rst_n)
        state == SR_WDT_RST && cfg.wdt_sel == WDT_SEL_25
        |-> cnt < CNT_W'(TO_SHORT))
        else $error("short time-out overran");
    AST_MR_DELAY: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(manual_reset_in) && state == SR_RUN && !filt[0]
        |=> (!reset_out) [*4])
        else $error("manual reset acted too fast");
    AST_WARN_LEADS: assert property (@(posedge clk) disable iff (!rst_n)
        state == SR_RUN ##1 state == SR_LOW_RST
        |-> $past(low_supply_warn, LR_CYC))
        else $error("reset before low-supply warning");
    AST_GLITCH: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(filt[1])
        |-> $past(manual_reset_in) && $past(manual_reset_in, 2))
        else $error("glitch passed filter");
    AST_NV_LEN: assert property (@(posedge clk) disable iff (!rst_n)
        nv_busy |-> nvc < CNT_W'(NVW))
        else $error("write cycle overran");
    AST_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
        state == SR_RUN && wdt_on && restart_evt && !filt[0] && !filt[1]
        |=> wdt == '0)
        else $error("restart did not reload watchdog");
    COV_WDT: cover property (@(posedge clk) state == SR_WDT_RST);
    COV_MAN: cover property (@(posedge clk) state == SR_MAN_RST);
    COV_LOW: cover property (@(posedge clk) state == SR_LOW_RST);
    COV_NV:  cover property (@(posedge clk) $fell(nv_busy));
endmodule

// ---- verif/srwt_host.sv ----
// host model: watchdog restart pulses and nonvolatile write requests
module srwt_host (
    input  wire logic       clk,
    input  wire logic       kick_en,
    input  wire logic [7:0] kick_len,
    input  wire logic [7:0] kick_gap,
    input  wire logic       wr_req,
    input  wire logic       wr_force,
    input  wire logic       nv_busy,
    output logic            wdt_restart,
    output logic            write_stop,
    output logic            wr_idle
);
    timeunit 1ns;
    timeprecision 1ns;
    int kc = 0;
    int wc = 0;
    int sc = 0;
    initial begin
        wdt_restart = 1'b0;
        write_stop = 1'b0;
        wr_idle = 1'b1;
    end
    // ------------------------------------------------------------
    // restart pulses, width and gap set by the bench
    // ------------------------------------------------------------
    always @(posedge clk) begin
        kc <= (!kick_en || kc >= kick_len + kick_gap - 1) ? 0 : kc + 1;
        wdt_restart <= kick_en && kc < kick_len;
    end
    // ------------------------------------------------------------
    // writes: polls busy rather than waiting the full write time
    // ------------------------------------------------------------
    always @(posedge clk) begin
        // stop held four cycles so it clears the input filter
        sc <= (wr_req && (wr_idle || wr_force)) ? 3 : (sc > 0 ? sc - 1 : 0);
        write_stop <= (wr_req && (wr_idle || wr_force)) || sc > 0;
        wc <= wr_idle ? 0 : wc + 1;
        if (wr_req && wr_idle) begin
            wr_idle <= 1'b0;
        end else if (wc > 8 && nv_busy === 1'b0) begin
            wr_idle <= 1'b1;
        end
    end
endmodule

// ---- verif/tb_top.sv ----
// testbench: timing checks of the reset and watchdog core
`define CHK(c, m) begin comparisons++; if ((c) !== 1'b1) begin \
    n_fail++; $display("[ERR] %0t %s", $time, m); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import srwt_pkg::*;
    // short timers keep the run brief
    localparam int POR[4] = '{20, 40, 60, 80};
    localparam int WDP[3] = '{150, 100, 60};
    localparam int TOL    = 50;
    localparam int TOS    = 30;
    localparam int NVWC   = 40;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    srwt_cfg_s  cfg;
    logic       supply_low, manual_reset_in, wdt_restart, write_stop;
    logic       reset_out, low_supply_warn, nv_busy;
    logic       kick_en, wr_req, wr_force, wr_idle;
    logic [7:0] kick_len, kick_gap;
    int         n_fail = 0;
    int         comparisons = 0;
    int         n, m;
    int unsigned rnd;
    always #50 clk = ~clk;
    srwt_top #(.POR_50(POR[0]), .POR_200(POR[1]), .POR_400(POR[2]),
        .POR_800(POR[3]), .WDT_1400(WDP[0]), .WDT_200(WDP[1]),
        .WDT_25(WDP[2]), .TO_LONG(TOL), .TO_SHORT(TOS), .NVW(NVWC)
    ) srwt_top_i (.clk(clk), .rst_n(rst_n), .cfg(cfg),
        .supply_low(supply_low), .manual_reset_in(manual_reset_in),
        .wdt_restart(wdt_restart), .write_stop(write_stop),
        .reset_out(reset_out), .low_supply_warn(low_supply_warn),
        .nv_busy(nv_busy));
    srwt_host srwt_host_i (.clk(clk), .kick_en(kick_en),
        .kick_len(kick_len), .kick_gap(kick_gap), .wr_req(wr_req),
        .wr_force(wr_force), .nv_busy(nv_busy),
        .wdt_restart(wdt_restart), .write_stop(write_stop),
        .wr_idle(wr_idle));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic sig(input int w);
        return w == 0 ? reset_out : w == 1 ? nv_busy : low_supply_warn;
    endfunction
    task automatic results();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wait_for(input int w, input logic v, input int bnd,
                            output int cnt);
        cnt = 0;
        while (sig(w) !== v) begin
            @(negedge clk);
            cnt++;
            if (cnt > bnd) begin
                n_fail++;
                $display("[ERR] %0t wait ran out", $time);
                results();
            end
        end
    endtask
    task automatic boot(input logic [1:0] ps, input logic [1:0] ws);
        int c;
        @(posedge clk);
        rst_n <= 1'b0;
        cfg <= '{por_sel: ps, wdt_sel: ws};
        repeat (3) @(posedge clk);
        @(negedge clk);
        `CHK(reset_out === 1'b1 && nv_busy === 1'b0, "reset state")
        @(posedge clk);
        rst_n <= 1'b1;
        wait_for(0, 1'b0, POR[ps] + 20, c);
        `CHK(c >= POR[ps] && c <= POR[ps] + 6, "power-on delay")
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        cfg = '{por_sel: POR_SEL_RST, wdt_sel: WDT_SEL_RST};
        supply_low = 1'b0;
        manual_reset_in = 1'b0;
        kick_en = 1'b0;
        kick_len = 8'h0a;
        kick_gap = 8'h14;
        wr_req = 1'b0;
        wr_force = 1'b0;
        rnd = $urandom(32'h92714ce6);
        repeat (5) @(posedge clk);
        for (int s = 0; s < 4; s++) boot(2'(s), WDT_SEL_OFF);
        m = 0;
        repeat (300) begin
            @(negedge clk);
            m += int'(reset_out !== 1'b0);
        end
        `CHK(m == 0, "watchdog off")
        for (int s = 0; s < 3; s++) begin
            boot(2'h0, 2'(s));
            wait_for(0, 1'b1, WDP[s] + 20, n);
            `CHK(n >= WDP[s] && n <= WDP[s] + 6, "period")
            m = (s == 2) ? TOS : TOL;
            wait_for(0, 1'b0, m + 20, n);
            `CHK(n >= m - 1 && n <= m + 6, "time-out")
            wait_for(0, 1'b1, WDP[s] + 20, n);
            `CHK(n >= WDP[s] - 2 && n <= WDP[s] + 6, "resume")
        end
        // random restart spacing, always inside the short period
        boot(2'h0, WDT_SEL_25);
        m = 0;
        repeat (4) begin
            // pause while spacing changes: no gap may fall under the filter
            @(posedge clk);
            kick_en <= 1'b0;
            kick_len <= 8'($urandom_range(14, 10));
            kick_gap <= 8'($urandom_range(20, 5));
            repeat (4) @(posedge clk);
            kick_en <= 1'b1;
            repeat (150) begin
                @(negedge clk);
                m += int'(reset_out !== 1'b0);
            end
        end
        `CHK(m == 0, "restarts held off reset")
        @(posedge clk);
        kick_len <= 8'h04;
        kick_gap <= 8'h06;
        wait_for(0, 1'b1, WDP[2] + 60, n);
        `CHK(reset_out === 1'b1, "short pulses ignored")
        @(posedge clk);
        kick_en <= 1'b0;
        boot(2'h0, WDT_SEL_OFF);
        @(posedge clk);
        manual_reset_in <= 1'b1;
        wait_for(0, 1'b1, 20, n);
        `CHK(n >= 5 && n <= 12, "manual delay")
        repeat (60) @(posedge clk);
        manual_reset_in <= 1'b0;
        wait_for(0, 1'b0, POR[0] + 20, n);
        `CHK(n >= POR[0] && n <= POR[0] + 8, "manual release")
        @(posedge clk);
        supply_low <= 1'b1;
        wait_for(2, 1'b1, 10, n);
        wait_for(0, 1'b1, 10, n);
        `CHK(n >= 4 && n <= 6 && low_supply_warn === 1'b1, "lead")
        @(posedge clk);
        supply_low <= 1'b0;
        wait_for(0, 1'b0, POR[0] + 20, n);
        `CHK(n >= POR[0] && n <= POR[0] + 8, "low release")
        // second stop inside the write must not stretch it
        @(posedge clk);
        wr_req <= 1'b1;
        @(posedge clk);
        wr_req <= 1'b0;
        wait_for(1, 1'b1, 8, n);
        repeat (10) @(negedge clk);
        @(posedge clk);
        wr_req <= 1'b1;
        wr_force <= 1'b1;
        @(posedge clk);
        wr_req <= 1'b0;
        wr_force <= 1'b0;
        wait_for(1, 1'b0, NVWC + 10, n);
        `CHK(n + 11 >= NVWC - 1 && n + 11 <= NVWC + 3, "write")
        repeat (12) @(negedge clk);
        `CHK(wr_idle === 1'b1, "host done")
        results();
    end
endmodule
